// File: hdl/hisel_top.sv
// Host interface select front end: strap capture, pin mux, byte link, interrupt line.
// Assumes pins are asynchronous; pad logic resolves the enables into wire levels.
// Notes on behaviour
// - Interface strap captured once at start-up
// - Strap low gives I2C, high gives SPI
// - SPI turns interface strap into MISO
// - Address strap captured at start-up
// - Address 0x66 when low, 0x67 high
// - I2C: data, clock pins, separate interrupt
// - SPI: MOSI, MISO, SCK, select, same interrupt
// - I2C works up to 400 kHz
// - SPI works up to 4 MHz
// - Select tied low permanently is accepted
// - SPI mode 0: sample rise, shift fall
// - Most significant bit first, both directions
module hisel_top (
  input  wire logic       CLOCK_I,
  input  wire logic       RST_B_I,
  input  wire logic       SHARED_DATA_CLOCK_PIN_I,
  output logic            SHARED_DATA_CLOCK_PIN_O,
  output logic            SHARED_DATA_CLOCK_PIN_OE_O,
  input  wire logic       SHARED_CLOCK_SELECT_PIN_I,
  output logic            SHARED_CLOCK_SELECT_PIN_O,
  output logic            SHARED_CLOCK_SELECT_PIN_OE_O,
  input  wire logic       INTERFACE_STRAP_PIN_I,
  output logic            INTERFACE_STRAP_PIN_O,
  output logic            INTERFACE_STRAP_PIN_OE_O,
  input  wire logic       ADDRESS_STRAP_PIN_I,
  output logic            HOST_INTERRUPT_OUT_O,
  output logic            HOST_INTERRUPT_OUT_OE_O,
  input  wire logic       REPORT_PENDING_I,
  input  wire logic [7:0] TX_BYTE_I,
  output logic            TX_TAKE_O,
  output logic [7:0]      RX_BYTE_O,
  output logic            RX_VALID_O,
  output logic            REPORT_READ_O,
  output logic            MODE_SPI_O,
  output logic [6:0]      I2C_ADDR_O,
  output logic            READY_O
);
  logic [3:0] pins_s;
  logic       sda_s, scl_s, istrap_s, astrap_s;
  logic       scl_d_r, sda_d_r;
  logic       captured_r;
  logic [7:0] wait_r;
  logic       spi_r;
  logic       addr_r;
  logic       addressed_r;
  logic       first_r;
  logic       ack_pend_r;
  logic       ack_drive_r;
  logic       i2c_rd_r;
  logic       pend_r;
  logic       in_frame_r;
  logic       ninth_r;
  hisel_link_if lnk ();

  hisel_sync #(.W(4)) u_sync (
    .clk_i   (CLOCK_I),
    .rst_b_i (RST_B_I),
    .d_i     ({SHARED_DATA_CLOCK_PIN_I, SHARED_CLOCK_SELECT_PIN_I, INTERFACE_STRAP_PIN_I, ADDRESS_STRAP_PIN_I}),
    .q_o     (pins_s)
  );
  assign {sda_s, scl_s, istrap_s, astrap_s} = pins_s;

  hisel_shift u_shift (
    .clk_i   (CLOCK_I),
    .rst_b_i (RST_B_I),
    .lnk     (lnk)
  );

  // Straps are sampled only after the synchroniser has settled past reset
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wait_r     <= 8'h00;
      captured_r <= 1'b0;
      spi_r      <= 1'b0;
      addr_r     <= 1'b0;
    end else if (!captured_r) begin
      if (wait_r == 8'(hisel_pkg::STRAP_WAIT_CY)) begin
        captured_r <= 1'b1;
        spi_r      <= istrap_s;
        addr_r     <= astrap_s;
      end else begin
        wait_r <= wait_r + 8'h01;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= spi_r ? sda_s : scl_s;
      sda_d_r <= sda_s;
    end
  end

  // SPI: clock on data/clock pin, select on clock/select pin, MOSI on address strap
  // The 50 MHz sampling covers 4 MHz SCK and 400 kHz SCL with wide margin
  always_comb begin
    if (spi_r) begin
      lnk.clk_rise   = captured_r && sda_s && !scl_d_r;
      lnk.clk_fall   = captured_r && !sda_s && scl_d_r;
      lnk.sel_active = captured_r && !scl_s;
      lnk.data_in    = astrap_s;
      lnk.start_ev   = 1'b0;
      lnk.stop_ev    = 1'b0;
    end else begin
      // The acknowledge clock is hidden so the byte counter stays aligned
      lnk.clk_rise   = captured_r && scl_s && !scl_d_r && !ninth_r;
      lnk.clk_fall   = captured_r && !scl_s && scl_d_r;
      lnk.sel_active = captured_r && in_frame_r;
      lnk.data_in    = sda_s;
      lnk.start_ev   = captured_r && scl_s && sda_d_r && !sda_s;
      lnk.stop_ev    = captured_r && scl_s && !sda_d_r && sda_s;
    end
  end
  assign lnk.tx_byte = TX_BYTE_I;

  // Ninth clock of each I2C byte carries the acknowledge, not data
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ninth_r <= 1'b0;
    end else if (lnk.start_ev || lnk.stop_ev) begin
      ninth_r <= 1'b0;
    end else if (!spi_r && lnk.rx_valid) begin
      ninth_r <= 1'b1;
    end else if (ninth_r && captured_r && scl_s && !scl_d_r) begin
      ninth_r <= 1'b0;
    end
  end

  // I2C framing: address match, ACK bit and direction
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      in_frame_r  <= 1'b0;
      first_r     <= 1'b0;
      addressed_r <= 1'b0;
      ack_pend_r  <= 1'b0;
      ack_drive_r <= 1'b0;
      i2c_rd_r    <= 1'b0;
    end else if (lnk.start_ev) begin
      in_frame_r  <= 1'b1;
      first_r     <= 1'b1;
      addressed_r <= 1'b0;
      ack_pend_r  <= 1'b0;
      ack_drive_r <= 1'b0;
    end else if (lnk.stop_ev) begin
      in_frame_r  <= 1'b0;
      addressed_r <= 1'b0;
      ack_drive_r <= 1'b0;
    end else if (!spi_r && lnk.rx_valid) begin
      first_r <= 1'b0;
      if (first_r) begin
        addressed_r <= (lnk.rx_byte[7:1] == I2C_ADDR_O);
        ack_pend_r  <= (lnk.rx_byte[7:1] == I2C_ADDR_O);
        i2c_rd_r    <= lnk.rx_byte[0];
      end else begin
        ack_pend_r <= addressed_r && !i2c_rd_r;
      end
    end else if (lnk.clk_fall && ack_pend_r) begin
      ack_drive_r <= 1'b1;
      ack_pend_r  <= 1'b0;
    end else if (lnk.clk_fall && ack_drive_r) begin
      ack_drive_r <= 1'b0;
    end
  end

  // Report pending line; read of a byte in the report clears it, new request wins
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pend_r <= 1'b0;
    end else if (REPORT_PENDING_I) begin
      pend_r <= 1'b1;
    end else if (REPORT_READ_O) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SHARED_DATA_CLOCK_PIN_O      <= 1'b0;
      SHARED_DATA_CLOCK_PIN_OE_O   <= 1'b0;
      SHARED_CLOCK_SELECT_PIN_O    <= 1'b0;
      SHARED_CLOCK_SELECT_PIN_OE_O <= 1'b0;
      INTERFACE_STRAP_PIN_O        <= 1'b0;
      INTERFACE_STRAP_PIN_OE_O     <= 1'b0;
      HOST_INTERRUPT_OUT_O         <= 1'b0;
      HOST_INTERRUPT_OUT_OE_O      <= 1'b0;
      TX_TAKE_O                    <= 1'b0;
      RX_BYTE_O                    <= 8'h00;
      RX_VALID_O                   <= 1'b0;
      REPORT_READ_O                <= 1'b0;
      MODE_SPI_O                   <= 1'b0;
      I2C_ADDR_O                   <= hisel_pkg::ADDR_LOW;
      READY_O                      <= 1'b0;
    end else begin
      MODE_SPI_O <= spi_r;
      I2C_ADDR_O <= addr_r ? hisel_pkg::ADDR_HIGH : hisel_pkg::ADDR_LOW;
      READY_O    <= captured_r;
      // SPI MISO on interface strap, high-Z while deselected
      INTERFACE_STRAP_PIN_O    <= lnk.data_out;
      INTERFACE_STRAP_PIN_OE_O <= captured_r && spi_r && lnk.sel_active;
      // I2C data is open drain: only ever pulls low
      SHARED_DATA_CLOCK_PIN_O    <= 1'b0;
      SHARED_DATA_CLOCK_PIN_OE_O <= captured_r && !spi_r && in_frame_r &&
                                    (ack_drive_r || (addressed_r && i2c_rd_r && !first_r && !lnk.data_out));
      // No stretching is done here; the clock pin stays released
      SHARED_CLOCK_SELECT_PIN_O    <= 1'b0;
      SHARED_CLOCK_SELECT_PIN_OE_O <= 1'b0;
      HOST_INTERRUPT_OUT_O         <= 1'b0;
      HOST_INTERRUPT_OUT_OE_O      <= captured_r && pend_r;
      RX_VALID_O    <= lnk.rx_valid && (spi_r || (!first_r && addressed_r && !i2c_rd_r));
      RX_BYTE_O     <= lnk.rx_byte;
      TX_TAKE_O     <= lnk.tx_take && (spi_r || (addressed_r && i2c_rd_r && !first_r));
      REPORT_READ_O <= lnk.tx_take && (spi_r || (addressed_r && i2c_rd_r && !first_r)) && pend_r;
    end
  end
endmodule // hisel_top

// File: hdl/hisel_pkg.sv
// Shared constants for the host interface select front end.
// Assumes a single 50 MHz device clock.
package hisel_pkg;
  localparam logic [6:0] ADDR_LOW      = 7'h66;
  localparam logic [6:0] ADDR_HIGH     = 7'h67;
  localparam int         CLK_HZ        = 50_000_000;
  localparam int         I2C_MAX_HZ    = 400_000;
  localparam int         SPI_MAX_HZ    = 4_000_000;
  localparam int         STRAP_WAIT_NS = 1000;
  localparam int         STRAP_WAIT_CY = (STRAP_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  typedef enum logic { HISEL_I2C, HISEL_SPI } hisel_mode_t;
endpackage

// File: hdl/hisel_link_if.sv
// Bundle between the pin front end and the serial engines.
// Assumes all signals are already synchronised to the device clock.
interface hisel_link_if;
  logic       clk_rise;
  logic       clk_fall;
  logic       sel_active;
  logic       data_in;
  logic       data_out;
  logic       start_ev;
  logic       stop_ev;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic [7:0] tx_byte;
  logic       tx_take;
  modport front  (output clk_rise, clk_fall, sel_active, data_in, start_ev, stop_ev, input data_out);
  modport engine (input clk_rise, clk_fall, sel_active, data_in, start_ev, stop_ev, output data_out,
                  output rx_byte, rx_valid, tx_take, input tx_byte);
endinterface

// File: hdl/hisel_sync.sv
// Two flip-flop synchroniser for pin levels.
// Assumes the input is asynchronous to the device clock.
module hisel_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // hisel_sync

// File: hdl/hisel_shift.sv
// MSB-first byte shifter used by both SPI and I2C personalities.
// Assumes edge pulses from the front end; data out changes on clock fall.
module hisel_shift (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  hisel_link_if.engine lnk
);
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r        <= 3'h0;
      sh_r         <= 8'h00;
      tx_r         <= hisel_pkg::RESET_BYTE;
      lnk.data_out <= 1'b0;
      lnk.rx_valid <= 1'b0;
      lnk.rx_byte  <= 8'h00;
      lnk.tx_take  <= 1'b0;
    end else begin
      lnk.rx_valid <= 1'b0;
      lnk.tx_take  <= 1'b0;
      if (!lnk.sel_active || lnk.start_ev || lnk.stop_ev) begin
        cnt_r        <= 3'h0;
        tx_r         <= lnk.tx_byte;
        lnk.data_out <= lnk.tx_byte[7];
      end else if (lnk.clk_rise) begin
        sh_r  <= {sh_r[6:0], lnk.data_in};
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
          lnk.rx_byte  <= {sh_r[6:0], lnk.data_in};
          lnk.rx_valid <= 1'b1;
          lnk.tx_take  <= 1'b1;
          tx_r         <= lnk.tx_byte;
        end
      end else if (lnk.clk_fall) begin
        lnk.data_out <= tx_r[3'h7 - cnt_r];
      end
    end
  end
endmodule // hisel_shift

// File: verif/hisel_assertions.sv
// Concurrent checks on the host interface select front end.
// Assumes a bind to hisel_top; sees its ports only.
module hisel_assertions (
  input wire logic       CLOCK_I,
  input wire logic       RST_B_I,
  input wire logic       SHARED_DATA_CLOCK_PIN_O,
  input wire logic       SHARED_DATA_CLOCK_PIN_OE_O,
  input wire logic       SHARED_CLOCK_SELECT_PIN_I,
  input wire logic       INTERFACE_STRAP_PIN_OE_O,
  input wire logic       HOST_INTERRUPT_OUT_O,
  input wire logic       HOST_INTERRUPT_OUT_OE_O,
  input wire logic       REPORT_PENDING_I,
  input wire logic       REPORT_READ_O,
  input wire logic       RX_VALID_O,
  input wire logic       MODE_SPI_O,
  input wire logic [6:0] I2C_ADDR_O,
  input wire logic       READY_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_B_I);
  addr_legal_a: assert property (I2C_ADDR_O == hisel_pkg::ADDR_LOW || I2C_ADDR_O == hisel_pkg::ADDR_HIGH)
    else $error("address off map");
  mode_hold_a: assert property (READY_O && $past(READY_O) |-> $stable(MODE_SPI_O))
    else $error("mode moved");
  addr_hold_a: assert property (READY_O && $past(READY_O) |-> $stable(I2C_ADDR_O))
    else $error("address moved");
  miso_gate_a: assert property (INTERFACE_STRAP_PIN_OE_O |-> MODE_SPI_O && READY_O)
    else $error("strap pin driven");
  miso_quiet_a: assert property (MODE_SPI_O && SHARED_CLOCK_SELECT_PIN_I [*6] |-> !INTERFACE_STRAP_PIN_OE_O)
    else $error("miso on while deselected");
  sck_input_a: assert property (MODE_SPI_O |-> !SHARED_DATA_CLOCK_PIN_OE_O)
    else $error("sck pin driven");
  od_low_a: assert property (!SHARED_DATA_CLOCK_PIN_O && !HOST_INTERRUPT_OUT_O)
    else $error("open drain drives high");
  irq_set_a: assert property (REPORT_PENDING_I |-> ##[1:3] HOST_INTERRUPT_OUT_OE_O)
    else $error("irq not raised");
  irq_release_a: assert property (REPORT_READ_O && !REPORT_PENDING_I |-> ##[1:3] !HOST_INTERRUPT_OUT_OE_O)
    else $error("irq not released");
  ss_ignore_a: assert property (MODE_SPI_O && SHARED_CLOCK_SELECT_PIN_I [*8] |-> !RX_VALID_O)
    else $error("byte while deselected");
  cover property (RX_VALID_O && MODE_SPI_O);
  cover property (READY_O && !MODE_SPI_O);
  cover property (REPORT_READ_O);
endmodule // hisel_assertions

// File: verif/hisel_host_model.sv
// Host SPI master model: mode 0, most significant bit first.
// Assumes the bench resolves MISO from pad enable and strap level.
module hisel_host_model #(
  parameter int HALF_NS = 80
) (
  output logic      sck,
  output logic      ss_b,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck  = 1'b0;
    ss_b = 1'b1;
    mosi = 1'b0;
  end
  // Half period of 80 ns; the 50 MHz sampling still sees every SCK edge
  task automatic xfer(input logic [7:0] tx, input logic keep_sel, output logic [7:0] rx);
    ss_b = 1'b0;
    #(2 * HALF_NS);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #HALF_NS;
      sck   = 1'b1;
      rx[i] = miso;
      #HALF_NS;
      sck = 1'b0;
    end
    #HALF_NS;
    ss_b = !keep_sel;
    mosi = ~mosi;
  endtask
  // Clocks with select high, which the device must ignore
  task automatic stray(input int n);
    repeat (n) begin
      #HALF_NS;
      sck = 1'b1;
      #HALF_NS;
      sck = 1'b0;
    end
  endtask
endmodule // hisel_host_model

// File: verif/test_host_interface_select.sv
// Bench for the host interface select front end.
// Assumes the host model drives SPI pins; pads are resolved here.
module test_host_interface_select;
  timeunit 1ns;
  timeprecision 100ps;
  logic       CLOCK_I = 1'b0;
  logic       RST_B_I = 1'b0;
  logic       REPORT_PENDING_I = 1'b0;
  logic [7:0] TX_BYTE_I = 8'ha5;
  logic       strap_lvl = 1'b1;
  logic       addr_lvl = 1'b1;
  logic       strapping = 1'b1;
  logic [7:0] rx_seen = 8'h00;
  logic [7:0] host_rx;
  logic       sda_h = 1'b1;
  logic       scl_h = 1'b1;
  int         rx_cnt = 0;
  int         errors = 0;
  int         comparisons = 0;
  int         cyc = 0;
  wire        sck, ss_b, mosi, strap_w, sd_o, sd_oe, sc_o, sc_oe, ms_o, ms_oe, irq_o, irq_oe, take, rxv, rd, spi, rdy;
  wire [7:0]  rxb;
  wire [6:0]  adr;
  always #10 CLOCK_I = ~CLOCK_I;
  // The strap level strap_lvl wins whenever the pad is not driving
  assign strap_w = ms_oe ? ms_o : strap_lvl;
  hisel_host_model hisel_host_model_i (.sck(sck), .ss_b(ss_b), .mosi(mosi), .miso(strap_w));
  hisel_top hisel_top_i (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
    .SHARED_DATA_CLOCK_PIN_I(spi ? sck : (sda_h & ~sd_oe)),
    .SHARED_DATA_CLOCK_PIN_O(sd_o), .SHARED_DATA_CLOCK_PIN_OE_O(sd_oe),
    .SHARED_CLOCK_SELECT_PIN_I(spi ? ss_b : (scl_h & ~sc_oe)),
    .SHARED_CLOCK_SELECT_PIN_O(sc_o), .SHARED_CLOCK_SELECT_PIN_OE_O(sc_oe),
    .INTERFACE_STRAP_PIN_I(strap_w), .INTERFACE_STRAP_PIN_O(ms_o), .INTERFACE_STRAP_PIN_OE_O(ms_oe),
    .ADDRESS_STRAP_PIN_I(strapping ? addr_lvl : mosi), .HOST_INTERRUPT_OUT_O(irq_o),
    .HOST_INTERRUPT_OUT_OE_O(irq_oe), .REPORT_PENDING_I(REPORT_PENDING_I), .TX_BYTE_I(TX_BYTE_I),
    .TX_TAKE_O(take), .RX_BYTE_O(rxb), .RX_VALID_O(rxv), .REPORT_READ_O(rd), .MODE_SPI_O(spi),
    .I2C_ADDR_O(adr), .READY_O(rdy));
  always @(posedge CLOCK_I) begin
    cyc <= cyc + 1;
    if (take === 1'b1) TX_BYTE_I <= ~TX_BYTE_I;
    if (rxv === 1'b1) begin
      rx_seen <= rxb;
      rx_cnt  <= rx_cnt + 1;
    end
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic start(input logic ifs, input logic adr_l);
    @(posedge CLOCK_I);
    strap_lvl <= ifs;
    addr_lvl  <= adr_l;
    strapping <= 1'b1;
    RST_B_I   <= 1'b0;
    repeat (3) @(posedge CLOCK_I);
    RST_B_I <= 1'b1;
    for (int i = 0; i < 200 && rdy !== 1'b1; i++) @(posedge CLOCK_I);
    @(posedge CLOCK_I);
    strapping <= 1'b0;
    check({7'h00, rdy}, 8'h01, "not ready");
  endtask
  // One I2C bit: data while SCL low, line sampled mid high
  task automatic i2c_bit(input logic b, output logic line);
    sda_h <= b;
    repeat (40) @(posedge CLOCK_I);
    scl_h <= 1'b1;
    for (int i = 0; i < 200 && sc_oe === 1'b1; i++) @(posedge CLOCK_I);
    repeat (20) @(posedge CLOCK_I);
    line = sda_h & ~sd_oe;
    repeat (20) @(posedge CLOCK_I);
    scl_h <= 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    logic l;
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], l);
    i2c_bit(1'b1, ack);
  endtask
  task automatic t_spi;
    start(1'b1, 1'b1);
    check({7'h00, spi}, 8'h01, "mode");
    check({1'b0, adr}, {1'b0, hisel_pkg::ADDR_HIGH}, "address");
    @(posedge CLOCK_I) strap_lvl <= 1'b0;
    repeat (10) @(posedge CLOCK_I);
    check({7'h00, spi}, 8'h01, "mode lost");
    hisel_host_model_i.xfer(8'h3c, 1'b0, host_rx);
    repeat (10) @(posedge CLOCK_I);
    check(rx_seen, 8'h3c, "mosi byte");
    check(host_rx, 8'ha5, "miso byte");
    hisel_host_model_i.stray(16);
    repeat (10) @(posedge CLOCK_I);
    check(rx_cnt[7:0], 8'h01, "clocks not ignored");
    hisel_host_model_i.xfer(8'hc3, 1'b1, host_rx);
    hisel_host_model_i.xfer(8'h81, 1'b0, host_rx);
    repeat (10) @(posedge CLOCK_I);
    check(rx_seen, 8'h81, "held select");
    check(rx_cnt[7:0], 8'h03, "byte count");
    @(posedge CLOCK_I) REPORT_PENDING_I <= 1'b1;
    @(posedge CLOCK_I) REPORT_PENDING_I <= 1'b0;
    repeat (4) @(posedge CLOCK_I);
    check({7'h00, irq_oe}, 8'h01, "irq set");
    hisel_host_model_i.xfer(8'h00, 1'b0, host_rx);
    repeat (10) @(posedge CLOCK_I);
    check({7'h00, irq_oe}, 8'h00, "irq held");
  endtask
  task automatic t_i2c;
    start(1'b0, 1'b0);
    check({7'h00, spi}, 8'h00, "mode");
    check({1'b0, adr}, {1'b0, hisel_pkg::ADDR_LOW}, "address");
    @(posedge CLOCK_I) strap_lvl <= 1'b1;
    repeat (10) @(posedge CLOCK_I);
    check({6'h00, ms_oe, spi}, 8'h00, "mode moved");
    t_i2c_write();
  endtask
  // Write of one data byte to our address, then STOP
  task automatic t_i2c_write;
    logic ack;
    @(posedge CLOCK_I) sda_h <= 1'b0;
    repeat (40) @(posedge CLOCK_I);
    scl_h <= 1'b0;
    i2c_byte({hisel_pkg::ADDR_LOW, 1'b0}, ack);
    check({7'h00, ack}, 8'h00, "address ack");
    i2c_byte(8'h5a, ack);
    check({7'h00, ack}, 8'h00, "data ack");
    check(rx_seen, 8'h5a, "i2c byte");
    check(rx_cnt[7:0], 8'h05, "i2c count");
    sda_h <= 1'b0;
    repeat (40) @(posedge CLOCK_I);
    scl_h <= 1'b1;
    repeat (40) @(posedge CLOCK_I);
    sda_h <= 1'b1;
    repeat (40) @(posedge CLOCK_I);
    check({7'h00, sd_oe}, 8'h00, "sda held after stop");
  endtask
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    t_spi();
    t_i2c();
    print_verdict();
  end
endmodule // test_host_interface_select
bind hisel_top hisel_assertions hisel_assertions_i (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
  .SHARED_DATA_CLOCK_PIN_O(SHARED_DATA_CLOCK_PIN_O), .SHARED_DATA_CLOCK_PIN_OE_O(SHARED_DATA_CLOCK_PIN_OE_O),
  .SHARED_CLOCK_SELECT_PIN_I(SHARED_CLOCK_SELECT_PIN_I), .INTERFACE_STRAP_PIN_OE_O(INTERFACE_STRAP_PIN_OE_O),
  .HOST_INTERRUPT_OUT_O(HOST_INTERRUPT_OUT_O), .HOST_INTERRUPT_OUT_OE_O(HOST_INTERRUPT_OUT_OE_O),
  .REPORT_PENDING_I(REPORT_PENDING_I), .REPORT_READ_O(REPORT_READ_O), .RX_VALID_O(RX_VALID_O),
  .MODE_SPI_O(MODE_SPI_O), .I2C_ADDR_O(I2C_ADDR_O), .READY_O(READY_O));
